// *** fec_front_end_regs.sv ***
`timescale 1ns/1ps
module fec_front_end_regs
   import fec_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic reg_wr_en_i,
   input wire logic [7:0] reg_wr_data_i,
   input wire logic reg_rd_en_i,
   output logic [7:0] reg_rd_data_o,
   input wire logic table_wr_en_i,
   input wire logic [2:0] table_wr_index_i,
   input wire logic [7:0] table_wr_data_i,
   input wire logic pump_cal_valid_i,
   input wire logic [3:0] pump_cal_result_i,
   input wire logic osc_cal_valid_i,
   input wire logic [4:0] osc_cal_result_i,
   input wire logic tx_active_i,
   input wire logic ook_mode_i,
   input wire logic tx_symbol_i,
   output logic [1:0] rx_amp_bias_o,
   output logic [1:0] rx_amp_to_mixer_bias_o,
   output logic [1:0] rx_lo_buffer_bias_o,
   output logic [1:0] rx_mixer_bias_o,
   output logic [1:0] tx_lo_buffer_bias_o,
   output logic [2:0] tx_level_index_o,
   output logic [1:0] cal_config_o,
   output logic pump_cal_stage_enable_o,
   output logic [3:0] pump_current_code_o,
   output logic osc_core_high_select_o,
   output logic [4:0] osc_current_code_o,
   output logic [2:0] pa_ramp_index_o,
   output logic [7:0] pa_setting_o,
   output logic pa_ramp_busy_o
);

   logic [1:0] rx_amp_bias_r;
   logic [1:0] rx_amp_to_mixer_bias_r;
   logic [1:0] rx_lo_buffer_bias_r;
   logic [1:0] rx_mixer_bias_r;
   logic [1:0] tx_lo_buffer_bias_r;
   logic [2:0] tx_level_index_r;
   logic [1:0] cal_config_r;
   logic [1:0] pump_cal_stage_en_r;
   logic [3:0] pump_current_r, pump_current_nxt;
   logic osc_core_high_select_r;
   logic [4:0] osc_current_r, osc_current_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;

   function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   // Address decode
   wire sel_rx_bias = reg_hit(reg_addr_i, RX_FRONT_END_BIAS_OFS);
   wire sel_tx_cfg = reg_hit(reg_addr_i, TX_FRONT_END_CONFIG_OFS);
   wire sel_pump_cal = reg_hit(reg_addr_i, PUMP_CAL_REGISTER_OFS);
   wire sel_osc_cal = reg_hit(reg_addr_i, OSC_CURRENT_CAL_REGISTER_OFS);
   wire wr_rx_bias = reg_wr_en_i && sel_rx_bias;
   wire wr_tx_cfg = reg_wr_en_i && sel_tx_cfg;
   wire wr_pump_cal = reg_wr_en_i && sel_pump_cal;
   wire wr_osc_cal = reg_wr_en_i && sel_osc_cal;

   // Read views; reserved bits fixed at zero
   wire [7:0] rx_bias_view = {rx_amp_bias_r, rx_amp_to_mixer_bias_r, rx_lo_buffer_bias_r, rx_mixer_bias_r};
   wire [7:0] tx_cfg_view = {2'h0, tx_lo_buffer_bias_r, 1'b0, tx_level_index_r};
   wire [7:0] pump_cal_view = {cal_config_r, pump_cal_stage_en_r, pump_current_r};
   wire [7:0] osc_cal_view = {2'h0, osc_core_high_select_r, osc_current_r};

   // Software write overrides a same-cycle calibration result
   assign pump_current_nxt = wr_pump_cal ? reg_wr_data_i[PUMP_CURRENT_LSB +: 4] :
                             pump_cal_valid_i ? pump_cal_result_i : pump_current_r;
   assign osc_current_nxt = wr_osc_cal ? reg_wr_data_i[OSC_CURRENT_LSB +: 5] :
                            osc_cal_valid_i ? osc_cal_result_i : osc_current_r;

   assign rd_data_nxt = sel_rx_bias ? rx_bias_view :
                        sel_tx_cfg ? tx_cfg_view :
                        sel_pump_cal ? pump_cal_view :
                        sel_osc_cal ? osc_cal_view : READ_ZERO;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         rx_amp_bias_r <= RX_AMP_BIAS_RST;
         rx_amp_to_mixer_bias_r <= RX_AMP_TO_MIXER_BIAS_RST;
         rx_lo_buffer_bias_r <= RX_LO_BUFFER_BIAS_RST;
         rx_mixer_bias_r <= RX_MIXER_BIAS_RST;
      end else if (wr_rx_bias) begin
         rx_amp_bias_r <= reg_wr_data_i[RX_AMP_BIAS_LSB +: 2];
         rx_amp_to_mixer_bias_r <= reg_wr_data_i[RX_AMP_TO_MIXER_BIAS_LSB +: 2];
         rx_lo_buffer_bias_r <= reg_wr_data_i[RX_LO_BUFFER_BIAS_LSB +: 2];
         rx_mixer_bias_r <= reg_wr_data_i[RX_MIXER_BIAS_LSB +: 2];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         tx_lo_buffer_bias_r <= TX_LO_BUFFER_BIAS_RST;
         tx_level_index_r <= TX_LEVEL_INDEX_RST;
      end else if (wr_tx_cfg) begin
         tx_lo_buffer_bias_r <= reg_wr_data_i[TX_LO_BUFFER_BIAS_LSB +: 2];
         tx_level_index_r <= reg_wr_data_i[TX_LEVEL_INDEX_LSB +: 3];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         cal_config_r <= CAL_CONFIG_RST;
         pump_cal_stage_en_r <= PUMP_CAL_STAGE_EN_RST;
      end else if (wr_pump_cal) begin
         cal_config_r <= reg_wr_data_i[CAL_CONFIG_LSB +: 2];
         pump_cal_stage_en_r <= reg_wr_data_i[PUMP_CAL_STAGE_EN_LSB +: 2];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         osc_core_high_select_r <= OSC_CORE_HIGH_SELECT_RST;
      end else if (wr_osc_cal) begin
         osc_core_high_select_r <= reg_wr_data_i[OSC_CORE_HIGH_SELECT_BIT];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         pump_current_r <= PUMP_CURRENT_RST;
         osc_current_r <= OSC_CURRENT_RST;
         rd_data_r <= READ_ZERO;
      end else begin
         pump_current_r <= pump_current_nxt;
         osc_current_r <= osc_current_nxt;
         if (reg_rd_en_i) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

   fec_pa_ramp u_ramp (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .tx_active_i(tx_active_i),
      .ook_mode_i(ook_mode_i),
      .tx_symbol_i(tx_symbol_i),
      .level_index_i(tx_level_index_r),
      .ramp_index_o(pa_ramp_index_o),
      .ramp_busy_o(pa_ramp_busy_o)
   );

   fec_power_table u_table (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .wr_en_i(table_wr_en_i),
      .wr_index_i(table_wr_index_i),
      .wr_data_i(table_wr_data_i),
      .rd_index_i(pa_ramp_index_o),
      .rd_data_o(pa_setting_o)
   );

   assign reg_rd_data_o = rd_data_r;
   assign rx_amp_bias_o = rx_amp_bias_r;
   assign rx_amp_to_mixer_bias_o = rx_amp_to_mixer_bias_r;
   assign rx_lo_buffer_bias_o = rx_lo_buffer_bias_r;
   assign rx_mixer_bias_o = rx_mixer_bias_r;
   assign tx_lo_buffer_bias_o = tx_lo_buffer_bias_r;
   assign tx_level_index_o = tx_level_index_r;
   assign cal_config_o = cal_config_r;
   assign pump_cal_stage_enable_o = (pump_cal_stage_en_r == PUMP_CAL_STAGE_EN_ON);
   assign pump_current_code_o = pump_current_r;
   assign osc_core_high_select_o = osc_core_high_select_r;
   assign osc_current_code_o = osc_current_r;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   a_pump_stage_gate: assert property (
      wr_pump_cal |=> pump_cal_stage_enable_o == ($past(reg_wr_data_i[5:4]) == 2'h1))
      else $error("pump calibration stage enable not decoded from value one");
   a_core_select_bit: assert property (
      wr_osc_cal |=> osc_core_high_select_o == $past(reg_wr_data_i[5]))
      else $error("oscillator core select does not follow written bit");
   a_pump_result_capture: assert property (
      pump_cal_valid_i && !wr_pump_cal |=> pump_current_code_o == $past(pump_cal_result_i))
      else $error("pump calibration result not captured");
   a_osc_result_capture: assert property (
      osc_cal_valid_i && !wr_osc_cal |=> osc_current_code_o == $past(osc_cal_result_i))
      else $error("oscillator calibration result not captured");
   a_osc_sw_override: assert property (
      wr_osc_cal ##1 (!osc_cal_valid_i && !wr_osc_cal)[*2] |-> osc_current_code_o == $past(reg_wr_data_i[4:0], 2))
      else $error("software oscillator override not held");
   a_rx_bias_drive: assert property (
      wr_rx_bias |=> rx_amp_bias_o == $past(reg_wr_data_i[7:6]))
      else $error("receive amplifier bias not driven from register");
   a_tx_lo_drive: assert property (
      wr_tx_cfg |=> tx_lo_buffer_bias_o == $past(reg_wr_data_i[5:4]))
      else $error("transmit LO buffer bias not driven from register");
   a_reserved_read: assert property (
      reg_rd_en_i && sel_tx_cfg |=> reg_rd_data_o[7:6] == 2'h0 && reg_rd_data_o[3] == 1'b0)
      else $error("reserved transmit config bits not zero");
   a_unmapped_read: assert property (
      reg_rd_en_i && !(sel_rx_bias || sel_tx_cfg || sel_pump_cal || sel_osc_cal) |=> reg_rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   a_level_index_write: assert property (
      wr_tx_cfg |=> tx_level_index_o == $past(reg_wr_data_i[2:0]))
      else $error("power index not taken from written field");

   c_hop_restore: cover property (wr_pump_cal ##1 wr_osc_cal ##1 tx_active_i);
   c_cal_capture: cover property (pump_cal_valid_i ##[1:4] osc_cal_valid_i);

endmodule

// *** fec_pa_ramp.sv ***
`timescale 1ns/1ps
module fec_pa_ramp
   import fec_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic tx_active_i,
   input wire logic ook_mode_i,
   input wire logic tx_symbol_i,
   input wire logic [2:0] level_index_i,
   output logic [2:0] ramp_index_o,
   output logic ramp_busy_o
);

   fec_ramp_state_type state_r, state_nxt;
   logic [2:0] index_r, index_nxt;
   logic [7:0] count_r;
   logic step_en;
   logic [2:0] target;

   function automatic logic [2:0] step_toward(input logic [2:0] cur, input logic [2:0] tgt);
      if (cur < tgt) begin
         step_toward = 3'(cur + PA_INDEX_ONE);
      end else if (cur > tgt) begin
         step_toward = 3'(cur - PA_INDEX_ONE);
      end else begin
         step_toward = cur;
      end
   endfunction

   // Step pulse divider
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || step_en) begin
         count_r <= RAMP_COUNT_ZERO;
      end else begin
         count_r <= 8'(count_r + RAMP_COUNT_ONE);
      end
   end
   assign step_en = (count_r == RAMP_STEP_LAST);

   // OOK in the active state only: symbol one uses the index, symbol zero entry zero; with ook_mode_i clear both use the index
   assign target = (state_r == RAMP_DOWN || state_r == RAMP_IDLE) ? PA_INDEX_ZERO :
                   (state_r == RAMP_ACTIVE && ook_mode_i && !tx_symbol_i) ? PA_INDEX_ZERO :
                   level_index_i;

   always_comb begin
      state_nxt = state_r;
      index_nxt = step_en ? step_toward(index_r, target) : index_r;
      case (state_r)
         RAMP_IDLE: begin
            index_nxt = PA_INDEX_ZERO;
            if (tx_active_i) begin
               state_nxt = RAMP_UP;
            end
         end
         RAMP_UP: begin
            if (!tx_active_i) begin
               state_nxt = RAMP_DOWN;
            end else if (index_nxt == level_index_i) begin
               state_nxt = RAMP_ACTIVE;
            end
         end
         RAMP_ACTIVE: begin
            if (!tx_active_i) begin
               state_nxt = RAMP_DOWN;
            end
         end
         RAMP_DOWN: begin
            if (tx_active_i) begin
               state_nxt = RAMP_UP;
            end else if (index_nxt == PA_INDEX_ZERO) begin
               state_nxt = RAMP_IDLE;
            end
         end
         default: begin
            state_nxt = RAMP_IDLE;
            index_nxt = PA_INDEX_ZERO;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state_r <= RAMP_IDLE;
         index_r <= PA_INDEX_ZERO;
      end else begin
         state_r <= state_nxt;
         index_r <= index_nxt;
      end
   end

   assign ramp_index_o = index_r;
   assign ramp_busy_o = (state_r != RAMP_IDLE);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   a_ramp_single_step: assert property (
      (index_r != $past(index_r)) |-> (index_r == 3'($past(index_r) + 3'h1) || index_r == 3'($past(index_r) - 3'h1)))
      else $error("ramp index jumped by more than one entry");
   a_ramp_no_step_idle: assert property (!step_en && state_r != RAMP_IDLE |=> index_r == $past(index_r))
      else $error("ramp index moved without a step pulse");
   a_ook_zero_symbol: assert property (
      state_r == RAMP_ACTIVE && ook_mode_i && !tx_symbol_i && tx_active_i && step_en && index_r != PA_INDEX_ZERO
      |=> index_r == 3'($past(index_r) - 3'h1))
      else $error("zero symbol does not shape toward entry zero");
   a_ook_one_symbol: assert property (
      state_r == RAMP_ACTIVE && ook_mode_i && tx_symbol_i && tx_active_i && step_en && index_r < level_index_i
      |=> index_r == 3'($past(index_r) + 3'h1))
      else $error("one symbol does not shape toward the power index");
   a_idle_index_zero: assert property (state_r == RAMP_IDLE |-> index_r == PA_INDEX_ZERO)
      else $error("idle ramp not at entry zero");

   c_ramp_up_done: cover property (state_r == RAMP_UP ##1 state_r == RAMP_ACTIVE);
   c_ramp_down_done: cover property (state_r == RAMP_DOWN ##1 state_r == RAMP_IDLE);
   c_ook_shaping: cover property (state_r == RAMP_ACTIVE && ook_mode_i && step_en && !tx_symbol_i);

endmodule

// *** fec_pkg.sv ***
package fec_pkg;

   // Register offsets on the register port
   localparam logic [5:0] RX_FRONT_END_BIAS_OFS = 6'h21;
   localparam logic [5:0] TX_FRONT_END_CONFIG_OFS = 6'h22;
   localparam logic [5:0] PUMP_CAL_REGISTER_OFS = 6'h23;
   localparam logic [5:0] OSC_CURRENT_CAL_REGISTER_OFS = 6'h24;

   // rx_front_end_bias fields
   localparam int RX_AMP_BIAS_LSB = 6;
   localparam int RX_AMP_TO_MIXER_BIAS_LSB = 4;
   localparam int RX_LO_BUFFER_BIAS_LSB = 2;
   localparam int RX_MIXER_BIAS_LSB = 0;
   localparam logic [1:0] RX_AMP_BIAS_RST = 2'h1;
   localparam logic [1:0] RX_AMP_TO_MIXER_BIAS_RST = 2'h1;
   localparam logic [1:0] RX_LO_BUFFER_BIAS_RST = 2'h1;
   localparam logic [1:0] RX_MIXER_BIAS_RST = 2'h2;

   // tx_front_end_config fields
   localparam int TX_LO_BUFFER_BIAS_LSB = 4;
   localparam int TX_LEVEL_INDEX_LSB = 0;
   localparam logic [1:0] TX_LO_BUFFER_BIAS_RST = 2'h1;
   localparam logic [2:0] TX_LEVEL_INDEX_RST = 3'h0;

   // pump_cal_register fields
   localparam int CAL_CONFIG_LSB = 6;
   localparam int PUMP_CAL_STAGE_EN_LSB = 4;
   localparam int PUMP_CURRENT_LSB = 0;
   localparam logic [1:0] CAL_CONFIG_RST = 2'h2;
   localparam logic [1:0] PUMP_CAL_STAGE_EN_RST = 2'h2;
   localparam logic [1:0] PUMP_CAL_STAGE_EN_ON = 2'h1;
   localparam logic [3:0] PUMP_CURRENT_RST = 4'h9;

   // osc_current_cal_register fields
   localparam int OSC_CORE_HIGH_SELECT_BIT = 5;
   localparam int OSC_CURRENT_LSB = 0;
   localparam logic OSC_CORE_HIGH_SELECT_RST = 1'b0;
   localparam logic [4:0] OSC_CURRENT_RST = 5'h0A;

   // Power level table
   localparam int PA_TABLE_DEPTH = 8;
   localparam logic [7:0] PA_TABLE_ENTRY_RST = 8'h00;
   localparam logic [2:0] PA_INDEX_ZERO = 3'h0;
   localparam logic [2:0] PA_INDEX_ONE = 3'h1;

   // Ramp step timing
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int RAMP_STEP_NS = 1000;
   localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [7:0] RAMP_STEP_LAST = 8'(RAMP_STEP_CYCLES - 1);
   localparam logic [7:0] RAMP_COUNT_ZERO = 8'h00;
   localparam logic [7:0] RAMP_COUNT_ONE = 8'h01;

   localparam logic [7:0] READ_ZERO = 8'h00;

   typedef enum logic [3:0] {
      RAMP_IDLE = 4'h1,
      RAMP_UP = 4'h2,
      RAMP_ACTIVE = 4'h4,
      RAMP_DOWN = 4'h8
   } fec_ramp_state_type;

endpackage

// *** fec_power_table.sv ***
`timescale 1ns/1ps
module fec_power_table
   import fec_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic wr_en_i,
   input wire logic [2:0] wr_index_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [2:0] rd_index_i,
   output logic [7:0] rd_data_o
);

   logic [7:0] entry_r [PA_TABLE_DEPTH];
   logic [7:0] rd_data_r;

   // Eight separately programmable amplifier settings
   always_ff @(posedge clock_i) begin
      for (int i = 0; i < PA_TABLE_DEPTH; i++) begin
         if (!rst_b_i) begin
            entry_r[i] <= PA_TABLE_ENTRY_RST;
         end else if (wr_en_i && (wr_index_i == 3'(i))) begin
            entry_r[i] <= wr_data_i;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         rd_data_r <= PA_TABLE_ENTRY_RST;
      end else begin
         rd_data_r <= entry_r[rd_index_i];
      end
   end

   assign rd_data_o = rd_data_r;

   a_table_write_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      wr_en_i ##1 (rd_index_i == $past(wr_index_i) && !wr_en_i) |=> rd_data_o == $past(wr_data_i, 2))
      else $error("power table entry does not return written setting");

endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
   import fec_pkg::*;
;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic reg_wr_en_i = 1'b0;
   logic [7:0] reg_wr_data_i = 8'h00;
   logic reg_rd_en_i = 1'b0;
   logic table_wr_en_i = 1'b0;
   logic [2:0] table_wr_index_i = 3'h0;
   logic [7:0] table_wr_data_i = 8'h00;
   logic pump_cal_valid_i = 1'b0;
   logic [3:0] pump_cal_result_i = 4'h0;
   logic osc_cal_valid_i = 1'b0;
   logic [4:0] osc_cal_result_i = 5'h00;
   logic tx_active_i = 1'b0;
   logic ook_mode_i = 1'b0;
   logic tx_symbol_i = 1'b0;
   logic [7:0] reg_rd_data_o;
   logic [1:0] rx_amp_bias_o, rx_amp_to_mixer_bias_o, rx_lo_buffer_bias_o, rx_mixer_bias_o;
   logic [1:0] tx_lo_buffer_bias_o, cal_config_o;
   logic [2:0] tx_level_index_o, pa_ramp_index_o;
   logic pump_cal_stage_enable_o, osc_core_high_select_o, pa_ramp_busy_o;
   logic [3:0] pump_current_code_o;
   logic [4:0] osc_current_code_o;
   logic [7:0] pa_setting_o;
   int err_count = 0;
   int samples_checked = 0;
   int cycle_count = 0;

   fec_front_end_regs u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wr_en_i(reg_wr_en_i), .reg_wr_data_i(reg_wr_data_i), .reg_rd_en_i(reg_rd_en_i),
      .reg_rd_data_o(reg_rd_data_o), .table_wr_en_i(table_wr_en_i), .table_wr_index_i(table_wr_index_i),
      .table_wr_data_i(table_wr_data_i), .pump_cal_valid_i(pump_cal_valid_i),
      .pump_cal_result_i(pump_cal_result_i), .osc_cal_valid_i(osc_cal_valid_i),
      .osc_cal_result_i(osc_cal_result_i), .tx_active_i(tx_active_i), .ook_mode_i(ook_mode_i),
      .tx_symbol_i(tx_symbol_i), .rx_amp_bias_o(rx_amp_bias_o), .rx_amp_to_mixer_bias_o(rx_amp_to_mixer_bias_o),
      .rx_lo_buffer_bias_o(rx_lo_buffer_bias_o), .rx_mixer_bias_o(rx_mixer_bias_o),
      .tx_lo_buffer_bias_o(tx_lo_buffer_bias_o), .tx_level_index_o(tx_level_index_o),
      .cal_config_o(cal_config_o), .pump_cal_stage_enable_o(pump_cal_stage_enable_o),
      .pump_current_code_o(pump_current_code_o), .osc_core_high_select_o(osc_core_high_select_o),
      .osc_current_code_o(osc_current_code_o), .pa_ramp_index_o(pa_ramp_index_o),
      .pa_setting_o(pa_setting_o), .pa_ramp_busy_o(pa_ramp_busy_o));

   always #4 clock_i = ~clock_i;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hang guard, well above the ramp waits
   always @(posedge clock_i) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 20000) begin
         err_count = err_count + 1;
         $display("[ERR] %0t timeout", $time);
         wrap_up();
      end
   end

   task automatic check_val(input logic [7:0] act, input logic [7:0] exp, input string what);
      samples_checked = samples_checked + 1;
      if (act !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] %0t %s got %h want %h", $time, what, act, exp);
      end
   endtask

   task automatic check_bit(input logic act, input logic exp, input string what);
      samples_checked = samples_checked + 1;
      if (act !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] %0t %s got %b want %b", $time, what, act, exp);
      end
   endtask

   task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
      @(posedge clock_i);
      reg_addr_i <= addr;
      reg_wr_data_i <= data;
      reg_wr_en_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_en_i <= 1'b0;
      #1;
   endtask

   task automatic reg_check(input logic [5:0] addr, input logic [7:0] exp);
      @(posedge clock_i);
      reg_addr_i <= addr;
      reg_rd_en_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_en_i <= 1'b0;
      #1;
      check_val(reg_rd_data_o, exp, "read");
   endtask

   task automatic wait_index(input logic [2:0] val);
      int n;
      // Step off the edge so the index is settled before the first look
      #1;
      for (n = 0; n < 600 && pa_ramp_index_o !== val; n++) begin
         @(posedge clock_i);
         #1;
      end
      check_val({5'h00, pa_ramp_index_o}, {5'h00, val}, "ramp index");
   endtask

   task automatic test_reset();
      reg_check(RX_FRONT_END_BIAS_OFS, 8'h56);
      reg_check(TX_FRONT_END_CONFIG_OFS, 8'h10);
      reg_check(PUMP_CAL_REGISTER_OFS, 8'hA9);
      reg_check(OSC_CURRENT_CAL_REGISTER_OFS, 8'h0A);
      check_bit(pump_cal_stage_enable_o, 1'b0, "pump enable");
      $display("test reset done");
   endtask

   task automatic test_fields();
      reg_write(RX_FRONT_END_BIAS_OFS, 8'hE4);
      check_val({rx_amp_bias_o, rx_amp_to_mixer_bias_o, rx_lo_buffer_bias_o, rx_mixer_bias_o},
         8'hE4, "rx bias");
      reg_write(TX_FRONT_END_CONFIG_OFS, 8'hFF);
      check_val({3'h0, tx_lo_buffer_bias_o, tx_level_index_o}, 8'h1F, "tx fields");
      reg_check(TX_FRONT_END_CONFIG_OFS, 8'h37);
      reg_write(OSC_CURRENT_CAL_REGISTER_OFS, 8'hFF);
      check_bit(osc_core_high_select_o, 1'b1, "core high");
      reg_check(OSC_CURRENT_CAL_REGISTER_OFS, 8'h3F);
      reg_write(OSC_CURRENT_CAL_REGISTER_OFS, 8'h15);
      check_bit(osc_core_high_select_o, 1'b0, "core low");
      reg_write(6'h25, 8'hFF);
      reg_check(6'h25, 8'h00);
      reg_check(RX_FRONT_END_BIAS_OFS, 8'hE4);
      $display("test fields done");
   endtask

   task automatic test_pump_enable();
      int v;
      for (v = 0; v < 4; v++) begin
         reg_write(PUMP_CAL_REGISTER_OFS, {2'h1, v[1:0], 4'h3});
         check_bit(pump_cal_stage_enable_o, v == 1, "pump enable");
         check_val({6'h00, cal_config_o}, 8'h01, "cal config");
      end
      $display("test pump enable done");
   endtask

   task automatic test_calibration();
      @(posedge clock_i);
      pump_cal_valid_i <= 1'b1;
      pump_cal_result_i <= 4'hC;
      osc_cal_valid_i <= 1'b1;
      osc_cal_result_i <= 5'h11;
      @(posedge clock_i);
      pump_cal_valid_i <= 1'b0;
      osc_cal_valid_i <= 1'b0;
      #1;
      check_val({4'h0, pump_current_code_o}, 8'h0C, "pump code");
      check_val({3'h0, osc_current_code_o}, 8'h11, "osc code");
      reg_check(PUMP_CAL_REGISTER_OFS, 8'h7C);
      reg_check(OSC_CURRENT_CAL_REGISTER_OFS, 8'h11);
      // Software value in the same cycle as a result must win
      @(posedge clock_i);
      reg_addr_i <= OSC_CURRENT_CAL_REGISTER_OFS;
      reg_wr_data_i <= 8'h2C;
      reg_wr_en_i <= 1'b1;
      osc_cal_valid_i <= 1'b1;
      osc_cal_result_i <= 5'h03;
      @(posedge clock_i);
      reg_wr_en_i <= 1'b0;
      osc_cal_valid_i <= 1'b0;
      #1;
      check_val({3'h0, osc_current_code_o}, 8'h0C, "osc override");
      check_bit(osc_core_high_select_o, 1'b1, "core after override");
      reg_write(PUMP_CAL_REGISTER_OFS, 8'h95);
      check_val({4'h0, pump_current_code_o}, 8'h05, "pump restore");
      $display("test calibration done");
   endtask

   task automatic test_ramp();
      int i;
      // Entry zero last, so it is read back while the ramp idles on it
      for (i = PA_TABLE_DEPTH - 1; i >= 0; i--) begin
         @(posedge clock_i);
         table_wr_en_i <= 1'b1;
         table_wr_index_i <= i[2:0];
         table_wr_data_i <= {5'h02, i[2:0]};
      end
      @(posedge clock_i);
      table_wr_en_i <= 1'b0;
      reg_write(TX_FRONT_END_CONFIG_OFS, 8'h13);
      check_val(pa_setting_o, 8'h10, "idle setting");
      @(posedge clock_i);
      tx_active_i <= 1'b1;
      @(posedge clock_i);
      #1;
      check_bit(pa_ramp_busy_o, 1'b1, "busy");
      wait_index(3'h1);
      wait_index(3'h2);
      wait_index(3'h3);
      @(posedge clock_i);
      #1;
      check_val(pa_setting_o, 8'h13, "level setting");
      @(posedge clock_i);
      ook_mode_i <= 1'b1;
      tx_symbol_i <= 1'b0;
      wait_index(3'h0);
      @(posedge clock_i);
      #1;
      check_val(pa_setting_o, 8'h10, "zero symbol");
      @(posedge clock_i);
      tx_symbol_i <= 1'b1;
      wait_index(3'h3);
      @(posedge clock_i);
      #1;
      check_val(pa_setting_o, 8'h13, "one symbol");
      @(posedge clock_i);
      tx_active_i <= 1'b0;
      wait_index(3'h2);
      wait_index(3'h0);
      repeat (2) @(posedge clock_i);
      #1;
      check_bit(pa_ramp_busy_o, 1'b0, "busy end");
      $display("test ramp done");
   endtask

   initial begin
      repeat (4) @(posedge clock_i);
      rst_b_i <= 1'b1;
      test_reset();
      test_fields();
      test_pump_enable();
      test_calibration();
      test_ramp();
      wrap_up();
   end
endmodule
